// ---- common/eeprom_pe_pkg.sv ----
package eeprom_pe_pkg;

    // array geometry
    localparam int          ARRAY_BYTES    = 512;
    localparam int          IDX_W          = 9;
    localparam int          BLOCK_BYTES    = 128;
    localparam int          BLOCK_COUNT    = 4;
    localparam int          BLK_W          = 2;

    // address map
    localparam logic [15:0] ARRAY_BASE     = 16'h0600;
    localparam logic [15:0] ARRAY_LAST     = 16'h07ff;
    localparam logic [15:0] SECURE_FIRST   = 16'h08f0;
    localparam logic [15:0] SECURE_LAST    = 16'h08ff;
    localparam logic [15:0] NVR_ADDR       = 16'h0fe0;

    // nonvolatile_config_reg fields
    localparam int          NVR_BP_LSB     = 0;
    localparam int          NVR_ARM_BIT    = 4;
    localparam logic [7:0]  NVR_FACTORY    = 8'hf0;
    localparam logic [7:0]  BYTE_ERASED    = 8'hff;
    // shadow before the first copy: every block protected
    localparam logic [7:0]  SHADOW_RESET   = 8'h0f;

    typedef enum logic [1:0] {
        MODE_PROGRAM    = 2'b00,
        MODE_BYTE_ERASE = 2'b01,
        MODE_BLOCK      = 2'b10,
        MODE_BULK       = 2'b11
    } erase_mode_t;

endpackage

// ---- verilog/eeprom_addr_decode.sv ----
`timescale 1ns/10ps
module eeprom_addr_decode
    import eeprom_pe_pkg::*;
(
    // address in
    input  wire logic [15:0]      i_addr,
    // classification
    output logic                  o_in_array,
    output logic                  o_is_nvr,
    output logic                  o_is_secure,
    output logic [IDX_W-1:0]      o_idx,
    output logic [BLK_W-1:0]      o_blk
);
    logic [15:0] offset;

    assign offset      = i_addr - ARRAY_BASE;
    assign o_in_array  = (i_addr >= ARRAY_BASE) && (i_addr <= ARRAY_LAST);
    assign o_is_nvr    = (i_addr == NVR_ADDR);
    assign o_is_secure = (i_addr >= SECURE_FIRST) && (i_addr <= SECURE_LAST);
    assign o_idx       = offset[IDX_W-1:0];
    assign o_blk       = offset[IDX_W-1:IDX_W-BLK_W];

endmodule

// ---- verilog/eeprom_cell_array.sv ----
`timescale 1ns/10ps
module eeprom_cell_array
    import eeprom_pe_pkg::*;
(
    // clock and power-on
    input  wire logic             i_ref_clk,
    input  wire logic             i_por_n,
    input  wire logic             i_ce,
    // read port
    input  wire logic [IDX_W-1:0] i_rd_idx,
    output logic [7:0]            o_rd_data,
    output logic [7:0]            o_nvr,
    // high-voltage operation
    input  wire logic             i_op_en,
    input  wire erase_mode_t      i_op_mode,
    input  wire logic             i_op_nvr,
    input  wire logic [IDX_W-1:0] i_op_idx,
    input  wire logic [7:0]       i_op_data
);
    typedef struct packed {
        logic [ARRAY_BYTES-1:0][7:0] mem;
        logic [7:0]                  nvr;
    } cells_t;

    cells_t                      st_r;
    cells_t                      st_nxt;
    logic [ARRAY_BYTES-1:0][7:0] mem_nxt;

    // programming only pulls ones to zero, erase returns to all ones
    genvar g;
    generate
        for (g = 0; g < ARRAY_BYTES; g++) begin : g_cell
            logic hit;
            logic blk_hit;
            assign hit     = (i_op_idx == IDX_W'(g)) && !i_op_nvr;
            assign blk_hit = (i_op_idx[IDX_W-1:IDX_W-BLK_W]
                              == BLK_W'(g / BLOCK_BYTES)) && !i_op_nvr;
            always_comb begin
                mem_nxt[g] = st_r.mem[g];
                if (i_op_en) begin
                    unique case (i_op_mode)
                        MODE_PROGRAM:    if (hit) mem_nxt[g] = st_r.mem[g] & i_op_data; // R1
                        MODE_BYTE_ERASE: if (hit) mem_nxt[g] = BYTE_ERASED;
                        MODE_BLOCK:      if (blk_hit) mem_nxt[g] = BYTE_ERASED; // R14
                        MODE_BULK:       mem_nxt[g] = BYTE_ERASED; // R14
                    endcase
                end
            end
        end
    endgenerate

    always_comb begin
        st_nxt     = st_r;
        st_nxt.mem = mem_nxt;
        if (i_op_en && i_op_nvr) begin
            if (i_op_mode == MODE_PROGRAM)
                st_nxt.nvr = st_r.nvr & i_op_data;
            else if (i_op_mode == MODE_BYTE_ERASE)
                st_nxt.nvr = BYTE_ERASED;
        end
    end

    // power-on leaves the part in its shipped state
    always_ff @(posedge i_ref_clk or negedge i_por_n) begin
        if (!i_por_n) begin
            st_r.mem <= {ARRAY_BYTES{BYTE_ERASED}}; // R2
            st_r.nvr <= NVR_FACTORY; // R2
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end

    assign o_rd_data = st_r.mem[i_rd_idx];
    assign o_nvr     = st_r.nvr;

endmodule

// ---- verilog/eeprom_pe_ctrl.sv ----
`timescale 1ns/10ps
// Overview of operation
// R1 - 512-byte array; erased bit is one, programming only clears bits
// R2 - ships erased, configuration bit 4 set, all blocks unprotected
// R3 - configuration copied to shadow at reset and on every config read
// R4 - only valid unprotected array bytes and the config byte are altered
// R5 - software programs: clear mode, latch, write, enable, wait, disable, unlatch
// R6 - mode pair zero means byte program, otherwise an erase mode
// R7 - latch captures valid array writes; later valid writes replace them
// R8 - while latched, array reads return the latched data
// R9 - with latch set, control writes ignored until a valid array write
// R10 - enable refused when latch clear and last write missed the array
// R11 - enable drives the charge pump; clearing it stops the pump
// R12 - clearing enable and latch together clears only the enable
// R13 - software erases: select mode, latch, write, enable, wait, disable, unlatch
// R14 - block erase clears a 128-byte block, bulk the array, config untouched
// R15 - mode selection frozen while the enable is set
// R16 - four 128-byte blocks each with a protect bit withholding voltage
// R17 - any protect bit blocks bulk erase; protected blocks never erased
// R18 - protect changes act only after reset or a config read
// R19 - armed security bit blocks program and erase of the secured range
// R20 - armed security disables block, bulk and config alterations
// R21 - armed: unsecured bytes still byte-erasable, secured bytes readable
// R22 - armed: writes to secured bytes are not valid array writes
// R23 - security cannot be disarmed; config frozen from arming on
// R24 - mode codes 00 program, 01 byte, 10 block, 11 bulk; reset clears
// R25 - latch may not be cleared while the enable is set
// R26 - software times program, erase and voltage fall itself
module eeprom_pe_ctrl
    import eeprom_pe_pkg::*;
(
    // clock, reset, enable
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_por_n,
    input  wire logic        i_ce,
    // cpu data access
    input  wire logic        i_bus_wr,
    input  wire logic        i_bus_rd,
    input  wire logic [15:0] i_bus_addr,
    input  wire logic [7:0]  i_bus_wdata,
    output logic [7:0]       o_bus_rdata,
    // program_control_reg write
    input  wire logic        i_ctrl_wr,
    input  wire logic        i_erase_select_high,
    input  wire logic        i_erase_select_low,
    input  wire logic        i_latch_enable,
    input  wire logic        i_program_voltage_enable,
    // program_control_reg and status
    output logic             o_erase_select_high,
    output logic             o_erase_select_low,
    output logic             o_latch_enable,
    output logic             o_program_voltage_enable,
    output logic             o_pump_on,
    output logic [7:0]       o_array_config_shadow,
    output logic             o_security_armed
);
    typedef struct packed {
        erase_mode_t      mode;
        logic             lat;
        logic             pgm;
        logic             latched;
        logic             last_arr;
        logic [IDX_W-1:0] lat_idx;
        logic             lat_nvr;
        logic [7:0]       lat_data;
        logic [7:0]       shadow;
        logic             load_pend;
        logic [7:0]       rdata;
        logic             pump;
        logic             armed;
    } ctrl_t;

    ctrl_t            st_r;
    ctrl_t            st_nxt;

    logic             bus_arr;
    logic             bus_nvr;
    logic             bus_sec;
    logic [IDX_W-1:0] bus_idx;
    logic [BLK_W-1:0] bus_blk;
    logic [7:0]       cell_rd;
    logic [7:0]       nvr_q;
    logic             armed_now;
    logic             wr_valid;
    logic             op_ok;
    logic [BLK_W-1:0] lat_blk;
    logic             op_en;

    eeprom_addr_decode u_dec (
        .i_addr      (i_bus_addr),
        .o_in_array  (bus_arr),
        .o_is_nvr    (bus_nvr),
        .o_is_secure (bus_sec),
        .o_idx       (bus_idx),
        .o_blk       (bus_blk)
    );

    eeprom_cell_array u_cells (
        .i_ref_clk (i_ref_clk),
        .i_por_n   (i_por_n),
        .i_ce      (i_ce),
        .i_rd_idx  (bus_idx),
        .o_rd_data (cell_rd),
        .o_nvr     (nvr_q),
        .i_op_en   (op_en),
        .i_op_mode (st_r.mode),
        .i_op_nvr  (st_r.lat_nvr),
        .i_op_idx  (st_r.lat_idx),
        .i_op_data (st_r.lat_data)
    );

    // arming is read live from the cell: once cleared no erase reaches it
    assign armed_now = !nvr_q[NVR_ARM_BIT]; // R19 R23
    assign lat_blk   = st_r.lat_idx[IDX_W-1:IDX_W-BLK_W];
    // voltage reaches the cells only while the present target is allowed,
    // so a new latch or a reload during the pulse cannot slip through
    assign op_en     = st_r.pump && op_ok; // R16 R17
    // this array never holds secured bytes, but a secured address must
    // never count as a valid write once armed
    assign wr_valid  = (bus_arr || bus_nvr)
                       && !(armed_now && bus_sec); // R22

    // decide whether the latched target may receive high voltage
    always_comb begin
        op_ok = 1'b0;
        if (st_r.lat_nvr) begin
            // config byte only by byte operations, never once armed
            op_ok = !armed_now
                    && (st_r.mode == MODE_PROGRAM
                        || st_r.mode == MODE_BYTE_ERASE); // R4 R14 R20
        end else begin
            unique case (st_r.mode)
                MODE_PROGRAM, MODE_BYTE_ERASE:
                    op_ok = !st_r.shadow[NVR_BP_LSB + lat_blk]; // R16 R21
                MODE_BLOCK:
                    op_ok = !st_r.shadow[NVR_BP_LSB + lat_blk]
                            && !armed_now; // R17 R20
                MODE_BULK:
                    op_ok = (st_r.shadow[NVR_BP_LSB+BLOCK_COUNT-1:NVR_BP_LSB]
                             == '0) && !armed_now; // R17 R20
            endcase
        end
    end

    always_comb begin
        st_nxt       = st_r;
        st_nxt.armed = armed_now;

        // first cycle after reset copies the configuration in
        if (st_r.load_pend) begin
            st_nxt.shadow    = nvr_q; // R3
            st_nxt.load_pend = 1'b0;
        end

        // data reads
        if (i_bus_rd) begin
            if (bus_nvr) begin
                st_nxt.rdata  = nvr_q;
                st_nxt.shadow = nvr_q; // R3 R18
            end else if (bus_arr) begin
                st_nxt.rdata = st_r.latched ? st_r.lat_data : cell_rd; // R8
            end else begin
                st_nxt.rdata = 8'h00;
            end
        end

        // data writes: captured only while the latch is set
        if (i_bus_wr) begin
            st_nxt.last_arr = wr_valid; // R10
            if (st_r.lat && wr_valid) begin
                st_nxt.latched  = 1'b1; // R7
                st_nxt.lat_idx  = bus_idx; // R7
                st_nxt.lat_nvr  = bus_nvr;
                st_nxt.lat_data = i_bus_wdata; // R7
            end
        end

        // control writes
        if (i_ctrl_wr && !(st_r.lat && !st_r.latched)) begin // R9
            if (!st_r.pgm)
                st_nxt.mode = erase_mode_t'({i_erase_select_high,
                                             i_erase_select_low}); // R6 R15 R24
            if (i_program_voltage_enable) begin
                if (st_r.pgm || st_r.lat || st_r.last_arr)
                    st_nxt.pgm = 1'b1; // R10
            end else begin
                st_nxt.pgm = 1'b0; // R11
            end
            if (i_latch_enable)
                st_nxt.lat = 1'b1;
            else if (!st_r.pgm)
                st_nxt.lat = 1'b0; // R12 R25
            if (!st_nxt.lat)
                st_nxt.latched = 1'b0;
            st_nxt.last_arr = 1'b0;
        end

        // the pump runs only with the latch set and a valid target latched
        st_nxt.pump = st_nxt.pgm && st_nxt.lat && st_nxt.latched
                      && op_ok; // R4 R11 R16
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r.mode      <= MODE_PROGRAM; // R24
            st_r.lat       <= 1'b0;
            st_r.pgm       <= 1'b0;
            st_r.latched   <= 1'b0;
            st_r.last_arr  <= 1'b0;
            st_r.lat_idx   <= '0;
            st_r.lat_nvr   <= 1'b0;
            st_r.lat_data  <= 8'h00;
            st_r.shadow    <= SHADOW_RESET;
            st_r.load_pend <= 1'b1; // R3 R18
            st_r.rdata     <= 8'h00;
            st_r.pump      <= 1'b0;
            st_r.armed     <= 1'b0;
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end

    assign o_bus_rdata              = st_r.rdata;
    assign o_erase_select_high      = st_r.mode[1];
    assign o_erase_select_low       = st_r.mode[0];
    assign o_latch_enable           = st_r.lat;
    assign o_program_voltage_enable = st_r.pgm;
    assign o_pump_on                = st_r.pump;
    assign o_array_config_shadow    = st_r.shadow;
    assign o_security_armed         = st_r.armed;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    lat_hold_a: assert property ( // R25
        st_r.lat && st_r.pgm |=> st_r.lat)
        else $error("latch cleared while enable set");

    pgm_refuse_a: assert property ( // R10
        i_ce && i_ctrl_wr && !st_r.pgm && !st_r.lat && !st_r.last_arr
        |=> !st_r.pgm)
        else $error("enable set without latch or array write");

    ctrl_ignore_a: assert property ( // R9
        i_ce && i_ctrl_wr && st_r.lat && !st_r.latched && !i_bus_wr
        |=> $stable(st_r.mode) && $stable(st_r.pgm) && st_r.lat)
        else $error("control write taken before valid write");

    mode_lock_a: assert property ( // R15
        st_r.pgm |=> $stable(st_r.mode))
        else $error("mode changed while enable set");

    pump_gate_a: assert property ( // R11
        st_r.pump |-> st_r.pgm && st_r.lat && st_r.latched)
        else $error("pump on without enable and latch");

    bulk_guard_a: assert property ( // R17
        op_en && st_r.mode == MODE_BULK
        |-> st_r.shadow[BLOCK_COUNT-1:0] == '0 && !armed_now)
        else $error("bulk erase with protection");

    latch_read_a: assert property ( // R8
        i_ce && i_bus_rd && bus_arr && st_r.latched && !i_bus_wr
        |=> o_bus_rdata == $past(st_r.lat_data))
        else $error("latched data not returned");

    nvr_reload_a: assert property ( // R3
        i_ce && i_bus_rd && bus_nvr
        |=> o_array_config_shadow == $past(nvr_q))
        else $error("shadow not reloaded on config read");

    latch_take_a: assert property ( // R7
        i_ce && i_bus_wr && wr_valid && st_r.lat && !i_ctrl_wr
        |=> st_r.latched && st_r.lat_idx == $past(bus_idx))
        else $error("valid write not latched");

    secure_skip_a: assert property ( // R22
        i_ce && i_bus_wr && bus_sec && armed_now && !st_r.latched
        && !i_ctrl_wr |=> !st_r.latched)
        else $error("secured write latched");

    ce_freeze_a: assert property ( // R11
        !i_ce |=> $stable(st_r))
        else $error("state moved while clock enable low");

    rdata_hold_a: assert property ( // R8
        !i_bus_rd
        |=> $stable(o_bus_rdata))
        else $error("read data changed without a read");

    shadow_hold_a: assert property ( // R18
        !i_bus_rd && !st_r.load_pend
        |=> $stable(o_array_config_shadow))
        else $error("protect settings changed without reload");

    protect_gate_a: assert property ( // R16
        op_en && !st_r.lat_nvr && st_r.mode != MODE_BULK
        |-> !st_r.shadow[NVR_BP_LSB + lat_blk])
        else $error("voltage applied to a protected block");

    nvr_guard_a: assert property ( // R20
        op_en && st_r.lat_nvr
        |-> !armed_now && (st_r.mode == MODE_PROGRAM
                           || st_r.mode == MODE_BYTE_ERASE))
        else $error("config byte altered while armed or by erase");

    erase_arm_a: assert property ( // R20
        op_en && (st_r.mode == MODE_BLOCK || st_r.mode == MODE_BULK)
        |-> !armed_now)
        else $error("block or bulk erase while armed");

    armed_stick_a: assert property ( // R23
        o_security_armed
        |=> o_security_armed)
        else $error("security disarmed");

    ctrl_mode_a: assert property ( // R24
        i_ce && i_ctrl_wr && !st_r.pgm && !(st_r.lat && !st_r.latched)
        |=> {o_erase_select_high, o_erase_select_low}
            == {$past(i_erase_select_high), $past(i_erase_select_low)})
        else $error("mode pair not taken from control write");

    pgm_grant_a: assert property ( // R10
        i_ce && i_ctrl_wr && i_program_voltage_enable
        && st_r.lat && st_r.latched
        |=> o_program_voltage_enable)
        else $error("enable refused after valid latched write");

    pump_stop_a: assert property ( // R11
        i_ce && i_ctrl_wr && !i_program_voltage_enable
        && !(st_r.lat && !st_r.latched)
        |=> !o_pump_on && !o_program_voltage_enable)
        else $error("pump left on after enable cleared");

    latch_keep_a: assert property ( // R12
        i_ce && i_ctrl_wr && st_r.pgm && !(st_r.lat && !st_r.latched)
        && !i_program_voltage_enable && !i_latch_enable
        |=> o_latch_enable == $past(st_r.lat))
        else $error("latch cleared together with enable");

    latch_clear_a: assert property ( // R8
        i_ce && i_ctrl_wr && !st_r.pgm && !i_latch_enable
        && !(st_r.lat && !st_r.latched)
        |=> !o_latch_enable && !st_r.latched)
        else $error("latch not released");

    cov_program_c: cover property (
        st_r.pump && st_r.mode == MODE_PROGRAM);
    cov_block_c: cover property (
        st_r.pump && st_r.mode == MODE_BLOCK);
    cov_reload_c: cover property (
        i_ce && i_bus_rd && bus_nvr);
    cov_bulk_c: cover property (
        op_en && st_r.mode == MODE_BULK);
    cov_ignore_c: cover property (
        i_ce && i_ctrl_wr && st_r.lat && !st_r.latched);

endmodule

// ---- testbench/eeprom_program_erase_control_test.sv ----
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; $display("Error %s expected %h seen %h", n, e, g); end end
module eeprom_program_erase_control_test;
    import eeprom_pe_pkg::*;
    logic        i_ref_clk;
    logic        i_rst_n;
    logic        i_por_n;
    logic        i_ce;
    logic        i_bus_wr;
    logic        i_bus_rd;
    logic [15:0] i_bus_addr;
    logic [7:0]  i_bus_wdata;
    logic        i_ctrl_wr;
    logic        i_erase_select_high;
    logic        i_erase_select_low;
    logic        i_latch_enable;
    logic        i_program_voltage_enable;
    logic [7:0]  o_bus_rdata;
    logic        o_erase_select_high;
    logic        o_erase_select_low;
    logic        o_latch_enable;
    logic        o_program_voltage_enable;
    logic        o_pump_on;
    logic [7:0]  o_array_config_shadow;
    logic        o_security_armed;
    logic [7:0]  mem [ARRAY_BYTES];
    logic [7:0]  nvr;
    logic [7:0]  shadow;
    logic [31:0] rng;
    int          failures;
    int          checks_done;
    int          cycles;

    eeprom_pe_ctrl DUT (.*);

    initial begin
        i_ref_clk = 1'b0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end

    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // cut a hang short
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("Error timeout expected %0d seen %0d", 0, cycles);
            wrap_up();
        end
    end

    function automatic logic [7:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[7:0];
    endfunction

    // would the pump be allowed to switch on for this target
    function automatic logic ok(input logic [1:0] m, input logic [15:0] a);
        int   b;
        logic armed;
        b = int'((a - ARRAY_BASE) >> 7);
        armed = !shadow[NVR_ARM_BIT];
        if (a == NVR_ADDR) return (m <= 2'b01) && !armed;
        case (m)
            2'b00, 2'b01: return !shadow[b];
            2'b10: return !shadow[b] && !armed;
            default: return shadow[3:0] == 4'h0 && !armed;
        endcase
    endfunction

    task automatic apply(input logic [1:0] m, input logic [15:0] a,
                         input logic [7:0] d);
        int i;
        i = int'(a - ARRAY_BASE);
        if (a == NVR_ADDR) begin
            nvr = (m == 2'b00) ? (nvr & d) : BYTE_ERASED;
        end else if (m == 2'b00) begin
            mem[i] = mem[i] & d;
        end else if (m == 2'b01) begin
            mem[i] = BYTE_ERASED;
        end else begin
            for (int j = 0; j < ARRAY_BYTES; j++) begin
                if (m == 2'b11 || j / BLOCK_BYTES == i / BLOCK_BYTES) begin
                    mem[j] = BYTE_ERASED;
                end
            end
        end
    endtask

    task automatic ctrl(input logic [1:0] m, input logic lat, input logic pgm);
        @(posedge i_ref_clk);
        i_ctrl_wr <= 1'b1;
        {i_erase_select_high, i_erase_select_low} <= m;
        i_latch_enable <= lat;
        i_program_voltage_enable <= pgm;
        @(posedge i_ref_clk);
        i_ctrl_wr <= 1'b0;
        @(negedge i_ref_clk);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_bus_wr <= 1'b1;
        i_bus_addr <= a;
        i_bus_wdata <= d;
        @(posedge i_ref_clk);
        i_bus_wr <= 1'b0;
        @(negedge i_ref_clk);
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e,
                      input string n);
        @(posedge i_ref_clk);
        i_bus_rd <= 1'b1;
        i_bus_addr <= a;
        @(posedge i_ref_clk);
        i_bus_rd <= 1'b0;
        @(negedge i_ref_clk);
        `CHK(n, e, o_bus_rdata)
    endtask

    task automatic rd_cfg();
        rd(NVR_ADDR, nvr, "config byte");
        shadow = nvr;
        `CHK("shadow", shadow, o_array_config_shadow)
        `CHK("armed", !shadow[NVR_ARM_BIT], o_security_armed)
    endtask

    task automatic verify();
        logic [15:0] list [7] = '{16'h0600, 16'h0690, 16'h0700, 16'h0710,
                                  16'h077f, 16'h0780, 16'h07ff};
        foreach (list[k]) rd(list[k], mem[list[k] - ARRAY_BASE], "array byte");
    endtask

    // full latch, write, enable, disable, unlatch sequence
    task automatic op(input logic [1:0] m, input logic [15:0] a,
                      input logic [7:0] d);
        logic e;
        e = ok(m, a);
        ctrl(m, 1'b1, 1'b0);
        `CHK("mode", m, {o_erase_select_high, o_erase_select_low})
        wr(16'h08f5, ~d);
        ctrl(m, 1'b1, 1'b1);
        `CHK("pgm ignored", 1'b0, o_program_voltage_enable)
        if (a != NVR_ADDR) wr(16'h0600, ~d);
        wr(a, d);
        if (a != NVR_ADDR) rd(a ^ 16'h0001, d, "latched read");
        ctrl(m, 1'b1, 1'b1);
        `CHK("pump on", e, o_pump_on)
        ctrl(~m, 1'b1, 1'b1);
        `CHK("mode frozen", m, {o_erase_select_high, o_erase_select_low})
        ctrl(m, 1'b0, 1'b0);
        `CHK("pump off", 1'b0, o_pump_on)
        `CHK("latch kept", 1'b1, o_latch_enable)
        ctrl(2'b00, 1'b0, 1'b0);
        `CHK("latch off", 1'b0, o_latch_enable)
        if (e) apply(m, a, d);
    endtask

    initial begin
        rng = 32'd93108;
        i_rst_n <= 1'b0;
        i_por_n <= 1'b0;
        i_ce <= 1'b1;
        i_bus_wr <= 1'b0;
        i_bus_rd <= 1'b0;
        i_bus_addr <= 16'h0000;
        i_bus_wdata <= 8'h00;
        i_ctrl_wr <= 1'b0;
        {i_erase_select_high, i_erase_select_low} <= 2'b00;
        i_latch_enable <= 1'b0;
        i_program_voltage_enable <= 1'b0;
        foreach (mem[i]) mem[i] = BYTE_ERASED;
        nvr = NVR_FACTORY;
        shadow = NVR_FACTORY;
        repeat (5) @(negedge i_ref_clk);
        `CHK("shadow in reset", SHADOW_RESET, o_array_config_shadow)
        `CHK("mode in reset", 2'b00, {o_erase_select_high, o_erase_select_low})
        @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        i_por_n <= 1'b1;
        repeat (2) @(negedge i_ref_clk);
        `CHK("shadow", NVR_FACTORY, o_array_config_shadow)
        verify();
        $display("test reset done");
        op(2'b00, 16'h0690, rnd());
        verify();
        op(2'b01, 16'h0690, rnd());
        op(2'b00, 16'h0710, rnd());
        op(2'b00, 16'h077f, rnd());
        op(2'b00, 16'h0780, rnd());
        verify();
        op(2'b10, 16'h0745, rnd());
        verify();
        op(2'b11, 16'h07ff, rnd());
        verify();
        $display("test program and erase done");
        wr(16'h0200, 8'h5a);
        ctrl(2'b00, 1'b0, 1'b1);
        `CHK("pgm refused", 1'b0, o_program_voltage_enable)
        $display("test enable refusal done");
        op(2'b01, NVR_ADDR, rnd());
        `CHK("shadow unchanged", shadow, o_array_config_shadow)
        op(2'b00, NVR_ADDR, 8'hf1);
        rd_cfg();
        op(2'b00, 16'h0600, rnd());
        op(2'b00, 16'h0690, rnd());
        op(2'b11, 16'h0690, rnd());
        verify();
        $display("test block protect done");
        op(2'b00, NVR_ADDR, 8'he1);
        rd_cfg();
        op(2'b10, 16'h0690, rnd());
        op(2'b01, NVR_ADDR, rnd());
        op(2'b01, 16'h0690, rnd());
        verify();
        rd_cfg();
        $display("test security done");
        @(posedge i_ref_clk);
        i_ce <= 1'b0;
        ctrl(2'b11, 1'b1, 1'b1);
        `CHK("frozen latch", 1'b0, o_latch_enable)
        `CHK("frozen pgm", 1'b0, o_program_voltage_enable)
        `CHK("frozen mode", 2'b00, {o_erase_select_high, o_erase_select_low})
        rd(16'h0690, nvr, "frozen read");
        @(posedge i_ref_clk);
        i_ce <= 1'b1;
        $display("test clock enable done");
        @(posedge i_ref_clk);
        i_rst_n <= 1'b0;
        repeat (2) @(negedge i_ref_clk);
        `CHK("latch in reset", 1'b0, o_latch_enable)
        @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        repeat (2) @(negedge i_ref_clk);
        `CHK("shadow reload", shadow, o_array_config_shadow)
        `CHK("still armed", 1'b1, o_security_armed)
        verify();
        $display("test second reset done");
        wrap_up();
    end
endmodule
